// ===== dv/fan_load.sv
// Fan load that tallies how many cycles its drive pin was high
`timescale 1ns/1ps
module fan_load (
    input  wire logic        core_clk, // Clock
    input  wire logic        pin,      // Fan drive pin
    input  wire logic        clr,      // Restart the tally
    output logic      [19:0] high_cnt  // High cycles seen
);
    // A fan averages its drive, so count asserted cycles
    always_ff @(posedge core_clk) begin
        high_cnt <= clr ? 20'h0 : high_cnt + {19'h0, pin};
    end
endmodule

// ===== dv/fan_output_duty_and_frequency_assertions.sv
// Port-level checks for the fan output block
`timescale 1ns/1ps
module fan_output_duty_and_frequency_assertions
    import fan_output_pkg::*;
#(
    parameter logic [7:0] SYS_FREQ_CFG = 8'h04 // System prescaler
)(
    input wire logic       core_clk,               // Clock
    input wire logic       nrst,                   // Reset
    input wire logic [2:0] io_offset,              // Port
    input wire logic       io_wr,                  // Write
    input wire logic       io_rd,                  // Read
    input wire logic [7:0] io_wdata,               // Wdata
    input wire logic [7:0] io_rdata,               // Rdata
    input wire logic       tick_fast,              // Fast tick
    input wire logic       tick_slow,              // Slow tick
    input wire logic [7:0] processor_fan_level,    // Duty
    input wire logic       processor_fan_pwm_mode, // Mode
    input wire logic       system_fan_output,      // Pin
    input wire logic [7:0] system_fan_dc_code,     // Code
    input wire logic       system_fan_dc_en,       // DC on
    input wire logic       processor_fan_output    // Pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Pin levels tied to mode and level
    AST_DC_PIN_LOW: assert property (system_fan_dc_en [*2] |-> !system_fan_output)
        else $error("pwm pin high in dc mode");
    AST_CPU_IDLE: assert property (
        !processor_fan_pwm_mode [*2] |-> !processor_fan_output)
        else $error("cpu pin high while not in pwm");
    AST_CPU_FULL: assert property (
        (processor_fan_pwm_mode && processor_fan_level == 8'hff) [*2] |-> processor_fan_output)
        else $error("cpu pin low at full level");
    AST_CPU_ZERO: assert property (
        (processor_fan_level == 8'h00) [*2] |-> !processor_fan_output)
        else $error("cpu pin high at zero level");
    AST_SYS_FULL: assert property (
        (!system_fan_dc_en && system_fan_dc_code == 8'hff) [*2] |-> system_fan_output)
        else $error("sys pin low at full level");
    AST_SYS_ZERO: assert property (
        (system_fan_dc_code == 8'h00) [*2] |-> !system_fan_output)
        else $error("sys pin high at zero level");

    // Register side effects only follow host accesses
    AST_RDATA_HOLD: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    AST_LEVEL_WRITE_ONLY: assert property (
        !io_wr && !$past(io_wr) |=> $stable(system_fan_dc_code))
        else $error("level changed without a write");

    cover property ($rose(system_fan_output) && !system_fan_dc_en);
    cover property ($rose(processor_fan_output) && tick_slow);
    cover property (io_rd ##1 io_rdata == 8'h40);
endmodule

// ===== dv/fan_output_duty_and_frequency_bench.sv
// Self-checking bench for the fan output block
`timescale 1ns/1ps
module fan_output_duty_and_frequency_bench
    import fan_output_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  io_offset = 3'h0;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  io_rdata;
    logic        tick_fast = 1'b1;
    logic        tick_slow = 1'b0;
    logic [7:0]  processor_fan_level = 8'h40;
    logic        processor_fan_pwm_mode = 1'b0;
    logic        system_fan_output;
    logic [7:0]  system_fan_dc_code;
    logic        system_fan_dc_en;
    logic        processor_fan_output;
    logic        clr = 1'b0;
    logic [19:0] sys_cnt;
    logic [19:0] cpu_cnt;
    int          num_errors = 0;
    int          num_checks = 0;

    // Clock of 100 ns period
    always #50 core_clk = ~core_clk;

    fan_output_duty_and_frequency #(.SYS_FREQ_CFG(8'h01)) dut (
        .core_clk, .nrst, .io_offset, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .tick_fast, .tick_slow, .processor_fan_level, .processor_fan_pwm_mode,
        .system_fan_output, .system_fan_dc_code, .system_fan_dc_en, .processor_fan_output
    );
    fan_load sys_fan (.core_clk, .pin(system_fan_output), .clr, .high_cnt(sys_cnt));
    fan_load cpu_fan (.core_clk, .pin(processor_fan_output), .clr, .high_cnt(cpu_cnt));

    task automatic final_report();
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One strobe on a host port, released at the next falling edge
    task automatic port_wr(input logic [2:0] o, input logic [7:0] d);
        @(negedge core_clk);
        io_offset = o;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge core_clk);
        io_wr = 1'b0;
    endtask

    task automatic reg_wr(input logic [6:0] idx, input logic [7:0] d);
        port_wr(PORT_ADDRESS, {1'b0, idx});
        port_wr(PORT_DATA, d);
    endtask

    // One read strobe on a host port; data stands right after the sampling edge
    task automatic port_rd(input logic [2:0] o, input logic [7:0] exp);
        @(negedge core_clk);
        io_offset = o;
        io_rd = 1'b1;
        @(negedge core_clk);
        io_rd = 1'b0;
        check({12'h0, io_rdata}, {12'h0, exp});
    endtask

    task automatic reg_rd(input logic [6:0] idx, input logic [7:0] exp);
        port_wr(PORT_ADDRESS, {1'b0, idx});
        port_rd(PORT_DATA, exp);
    endtask

    // Level is loaded through the second bank only
    task automatic set_level(input logic [7:0] lv);
        reg_wr(IDX_BANK_SELECT, 8'h01);
        reg_wr(IDX_SYS_LEVEL_WRITE, lv);
        reg_wr(IDX_BANK_SELECT, 8'h00);
    endtask

    // Settle one window, then tally both pins over the next
    task automatic meas(input int n, input logic [19:0] es, input logic [19:0] ec);
        repeat (n) @(negedge core_clk);
        clr = 1'b1;
        @(negedge core_clk);
        clr = 1'b0;
        repeat (n) @(negedge core_clk);
        check(sys_cnt, es);
        check(cpu_cnt, ec);
    endtask

    task automatic test_reset_map();
        reg_rd(IDX_SYS_LEVEL, 8'hff);
        reg_rd(IDX_CPU_FREQ, 8'h04);
        reg_rd(IDX_SYS_MODE, 8'h01);
        reg_rd(7'h7f, 8'h00);
        port_rd(PORT_ADDRESS, 8'h7f);
        port_rd(3'h0, 8'h00);
        reg_rd(IDX_BANK_SELECT, 8'h00);
        check({19'h0, system_fan_dc_en}, 20'h1);
        reg_wr(IDX_SYS_LEVEL, 8'h00);
        reg_rd(IDX_SYS_LEVEL, 8'hff);
    endtask

    task automatic test_sys_pwm();
        logic [7:0]  lv [3] = '{8'h00, 8'h40, 8'hff};
        logic [19:0] es;
        set_level(8'h40);
        reg_rd(IDX_SYS_LEVEL, 8'h40);
        check({12'h0, system_fan_dc_code}, 20'h40);
        reg_wr(IDX_SYS_MODE, 8'h00);
        reg_rd(IDX_SYS_MODE, 8'h00);
        check({19'h0, system_fan_dc_en}, 20'h0);
        foreach (lv[i]) begin
            set_level(lv[i]);
            es = (lv[i] == 8'hff) ? 20'h200 : {11'h0, lv[i], 1'b0};
            meas(512, es, 20'h0);
        end
    endtask

    // Nonzero prescale fields only, on both sources
    task automatic test_cpu_freq();
        logic [7:0] cfg [4] = '{8'hf1, 8'h88, 8'h01, 8'h03};
        int         div [4] = '{2, 12, 2, 4};
        processor_fan_pwm_mode = 1'b1;
        foreach (cfg[i]) begin
            tick_fast = !cfg[i][7];
            tick_slow = cfg[i][7];
            reg_wr(IDX_CPU_FREQ, cfg[i]);
            reg_rd(IDX_CPU_FREQ, cfg[i]);
            meas(256 * div[i], 20'(256 * div[i]), 20'(64 * div[i]));
        end
        processor_fan_level = 8'hff;
        meas(512, 20'h200, 20'h200);
        processor_fan_level = 8'h00;
        meas(512, 20'h200, 20'h0);
        processor_fan_level = 8'hff;
        processor_fan_pwm_mode = 1'b0;
        meas(512, 20'h200, 20'h0);
    endtask

    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        test_reset_map();
        test_sys_pwm();
        test_cpu_freq();
        final_report();
    end

    // Watchdog well beyond the expected run of about 16000 cycles
    initial begin
        #4000000;
        num_errors++;
        final_report();
    end
endmodule

bind fan_output_duty_and_frequency fan_output_duty_and_frequency_assertions
    #(.SYS_FREQ_CFG(SYS_FREQ_CFG)) chk (
    .core_clk, .nrst, .io_offset, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .tick_fast, .tick_slow, .processor_fan_level, .processor_fan_pwm_mode,
    .system_fan_output, .system_fan_dc_code, .system_fan_dc_en, .processor_fan_output
);

// ===== src/fan_output_duty_and_frequency.sv
// Fan output level, mode and PWM frequency registers behind an index/data port
`timescale 1ns/1ps

// Behaviour
// - System fan level readable at bank0 01h, resets FFh
// - PWM mode duty equals level over 255; the code gives level over 256 below FFh
// - FFh gives full on, 00h full off
// - DC mode presents level as voltage code
// - Level written only through bank1 index 09
// - Frequency bit 7 selects fast or slow source
// - Processor frequency only acts in PWM operation
// - Frequency is source over divisor over 256
// - Fast source divisor is field plus one
// - Slow source maps low four bits to divisor
// - Bank0 04h bit 0 selects PWM or DC
// - Index written at base+5, data at base+6
module fan_output_duty_and_frequency
    import fan_output_pkg::*;
#(
    parameter logic [7:0] SYS_FREQ_CFG = RST_SYS_FREQ  // System fan prescaler setting
)(
    input  wire logic       core_clk,               // Core clock, 10 MHz
    input  wire logic       nrst,                   // Async reset, active low
    input  wire logic [2:0] io_offset,              // Port offset from base
    input  wire logic       io_wr,                  // Write strobe, one cycle
    input  wire logic       io_rd,                  // Read strobe, one cycle
    input  wire logic [7:0] io_wdata,               // Write data
    output logic      [7:0] io_rdata,               // Read data, valid after io_rd
    input  wire logic       tick_fast,              // Pulse per fast source edge
    input  wire logic       tick_slow,              // Pulse per slow source edge
    input  wire logic [7:0] processor_fan_level,    // Processor fan duty level
    input  wire logic       processor_fan_pwm_mode, // Processor fan set for PWM
    output logic            system_fan_output,      // System fan PWM pin
    output logic      [7:0] system_fan_dc_code,     // DC voltage code
    output logic            system_fan_dc_en,       // DC drive active
    output logic            processor_fan_output    // Processor fan PWM pin
);

    logic [6:0]           index_ptr;
    logic [BANK_BITS-1:0] bank;
    logic [7:0]           fan_level_code;
    pwm_freq_s            cpu_freq;
    logic                 sys_mode_dc;
    logic                 data_wr;
    logic                 main_bank;
    logic [7:0]           read_value;

    assign data_wr   = io_wr && (io_offset == PORT_DATA);
    assign main_bank = (bank == BANK_MAIN);

    // Index pointer written through the address port
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            index_ptr <= '0;
        end else if (io_wr && io_offset == PORT_ADDRESS) begin
            index_ptr <= io_wdata[6:0];
        end
    end

    // Bank select, reachable from every bank
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bank <= RST_BANK;
        end else if (data_wr && index_ptr == IDX_BANK_SELECT) begin
            bank <= io_wdata[BANK_BITS-1:0];
        end
    end

    // System fan level: read-only in bank0, written via the bank1 alias
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fan_level_code <= RST_SYS_LEVEL;
        end else if (data_wr && bank == BANK_SYS_LEVEL_WRITE
                     && index_ptr == IDX_SYS_LEVEL_WRITE) begin
            fan_level_code <= io_wdata;
        end
    end

    // Processor fan frequency configuration
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_freq <= pwm_freq_s'(RST_CPU_FREQ);
        end else if (data_wr && main_bank && index_ptr == IDX_CPU_FREQ) begin
            cpu_freq <= pwm_freq_s'(io_wdata);
        end
    end

    // System fan output mode
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sys_mode_dc <= RST_SYS_MODE_DC;
        end else if (data_wr && main_bank && index_ptr == IDX_SYS_MODE) begin
            sys_mode_dc <= io_wdata[SYS_MODE_BIT];
        end
    end

    // Data port read decode; unmapped indexes read as zero
    always_comb begin
        read_value = READ_IDLE;
        if (index_ptr == IDX_BANK_SELECT) begin
            read_value = {{(8-BANK_BITS){1'b0}}, bank};
        end else if (main_bank) begin
            unique case (index_ptr)
                IDX_SYS_LEVEL: read_value = fan_level_code;
                IDX_CPU_FREQ:  read_value = cpu_freq;
                IDX_SYS_MODE:  read_value = {7'h00, sys_mode_dc};
                default:       read_value = READ_IDLE;
            endcase
        end
    end

    // Registered read data, updated on each read strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= READ_IDLE;
        end else if (io_rd) begin
            if (io_offset == PORT_ADDRESS) begin
                io_rdata <= {1'b0, index_ptr};
            end else if (io_offset == PORT_DATA) begin
                io_rdata <= read_value;
            end else begin
                io_rdata <= READ_IDLE;
            end
        end
    end

    // DC drive: the level stands as a code for the 256-step voltage converter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            system_fan_dc_code <= RST_SYS_LEVEL;
            system_fan_dc_en   <= RST_SYS_MODE_DC;
        end else begin
            system_fan_dc_code <= fan_level_code;
            system_fan_dc_en   <= sys_mode_dc;
        end
    end

    // System fan PWM channel, held low in DC mode
    fan_pwm_core u_system_fan (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .tick_fast (tick_fast),
        .tick_slow (tick_slow),
        .freq      (pwm_freq_s'(SYS_FREQ_CFG)),
        .level     (fan_level_code),
        .enable    (!sys_mode_dc),
        .pwm       (system_fan_output)
    );

    // Processor fan PWM channel, frequency settings act only in PWM operation
    fan_pwm_core u_processor_fan (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .tick_fast (tick_fast),
        .tick_slow (tick_slow),
        .freq      (cpu_freq),
        .level     (processor_fan_level),
        .enable    (processor_fan_pwm_mode),
        .pwm       (processor_fan_output)
    );

endmodule

// ===== src/fan_output_pkg.sv
// Constants and carrier types shared by the fan output logic
package fan_output_pkg;

    // Host port offsets from the monitor base address
    localparam logic [2:0] PORT_ADDRESS         = 3'h5;
    localparam logic [2:0] PORT_DATA            = 3'h6;

    // Banks and register indexes
    localparam logic [2:0] BANK_MAIN            = 3'h0;
    localparam logic [2:0] BANK_SYS_LEVEL_WRITE = 3'h1;
    localparam logic [6:0] IDX_SYS_LEVEL        = 7'h01;
    localparam logic [6:0] IDX_CPU_FREQ         = 7'h02;
    localparam logic [6:0] IDX_SYS_MODE         = 7'h04;
    localparam logic [6:0] IDX_SYS_LEVEL_WRITE  = 7'h09;
    localparam logic [6:0] IDX_BANK_SELECT      = 7'h4e;

    // Field positions
    localparam int         SYS_MODE_BIT         = 0;
    localparam int         BANK_BITS            = 3;

    // Reset values
    localparam logic [7:0] RST_SYS_LEVEL        = 8'hff;
    localparam logic [7:0] RST_CPU_FREQ         = 8'h04;
    localparam logic       RST_SYS_MODE_DC      = 1'h1;
    localparam logic [7:0] RST_SYS_FREQ         = 8'h04;
    localparam logic [2:0] RST_BANK             = 3'h0;
    localparam logic [7:0] READ_IDLE            = 8'h00;

    // PWM shape
    localparam logic [7:0] LEVEL_FULL           = 8'hff;
    localparam int         DIV_WIDTH            = 11;

    // Prescaler setting of a fan PWM: source select and divisor field
    typedef struct packed {
        logic       tick_source_select;
        logic [6:0] prescale;
    } pwm_freq_s;

endpackage

// ===== src/fan_pwm_core.sv
// One fan PWM channel: prescaler, 256-step period counter and duty compare
`timescale 1ns/1ps
module fan_pwm_core
    import fan_output_pkg::*;
(
    input  wire logic      core_clk,    // Core clock
    input  wire logic      nrst,        // Async reset, active low
    input  wire logic      tick_fast,   // One-cycle pulse per fast source edge
    input  wire logic      tick_slow,   // One-cycle pulse per slow source edge
    input  wire pwm_freq_s freq,        // Source select and divisor
    input  wire logic [7:0] level,      // Duty level
    input  wire logic      enable,      // Channel runs in PWM mode
    output logic           pwm          // Registered PWM output
);

    logic [DIV_WIDTH-1:0] divisor;
    logic [DIV_WIDTH-1:0] pre_cnt;
    logic [7:0]           step;
    logic                 src_tick;
    logic                 step_tick;

    // Slow source uses only the low four divisor bits through a mapping table
    function automatic logic [DIV_WIDTH-1:0] slow_divisor(input logic [3:0] code);
        logic [DIV_WIDTH-1:0] d;
        d = '0;
        unique case (code)
            4'h8: d = 11'd12;
            4'h9: d = 11'd16;
            4'ha: d = 11'd32;
            4'hb: d = 11'd64;
            4'hc: d = 11'd128;
            4'hd: d = 11'd256;
            4'he: d = 11'd512;
            4'hf: d = 11'd1024;
            default: d = {7'h00, code} + 11'd1; // Codes 0..7 give 1..8
        endcase
        return d;
    endfunction

    // Divisor and source selection
    always_comb begin
        if (freq.tick_source_select) begin
            divisor  = slow_divisor(freq.prescale[3:0]);
            src_tick = tick_slow;
        end else begin
            divisor  = {4'h0, freq.prescale} + 11'd1;
            src_tick = tick_fast;
        end
    end

    assign step_tick = src_tick && (pre_cnt >= divisor - 11'd1);

    // Prescaler divides the selected source
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt <= '0;
        end else if (!enable) begin
            pre_cnt <= '0;
        end else if (step_tick) begin
            pre_cnt <= '0;
        end else if (src_tick) begin
            pre_cnt <= pre_cnt + 11'd1;
        end
    end

    // Period of 256 prescaled steps
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            step <= '0;
        end else if (!enable) begin
            step <= '0;
        end else if (step_tick) begin
            step <= step + 8'h01;
        end
    end

    // Duty compare; full level holds the output for the whole period
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pwm <= 1'b0;
        end else if (!enable) begin
            pwm <= 1'b0;
        end else begin
            pwm <= (level == LEVEL_FULL) || (step < level);
        end
    end

endmodule
